// File: core/dct_defs.vh
`ifndef DCT_DEFS_VH
`define DCT_DEFS_VH

// Register indices; byte address is four times the index
`define DCT_IDX_CTL 8'h88
`define DCT_IDX_MODE 8'h89
`define DCT_IDX_TLA 8'h8a
`define DCT_IDX_TLB 8'h8b
`define DCT_IDX_THA 8'h8c
`define DCT_IDX_THB 8'h8d
`define DCT_IDX_CLKSEL 8'h8e
`define DCT_IDX_IEN 8'ha8
`define DCT_IDX_ICFG 8'he4

// Reset values
`define DCT_RST_CTL 8'h00
`define DCT_RST_MODE 8'h00
`define DCT_RST_CNT 8'h00
`define DCT_RST_CLKSEL 8'h00
`define DCT_RST_IEN 8'h00
`define DCT_RST_ICFG 8'h00

// Clock select fields
`define DCT_CKS_PS 0
`define DCT_CKS_TA 2
`define DCT_CKS_TB 3
`define DCT_CKS_T2L 4
`define DCT_CKS_T2H 5
`define DCT_CKS_T3L 6
`define DCT_CKS_T3H 7

// Control fields
`define DCT_CTL_TFB 7
`define DCT_CTL_TRB 6
`define DCT_CTL_TFA 5
`define DCT_CTL_TRA 4
`define DCT_CTL_IEB 3
`define DCT_CTL_ITB 2
`define DCT_CTL_IEA 1
`define DCT_CTL_ITA 0

// Mode fields
`define DCT_MOD_GATEB 7
`define DCT_MOD_CTB 6
`define DCT_MOD_MDB 4
`define DCT_MOD_GATEA 3
`define DCT_MOD_CTA 2
`define DCT_MOD_MDA 0

// Enable and polarity fields
`define DCT_IEN_TA 1
`define DCT_IEN_TB 3
`define DCT_ICFG_PLA 3
`define DCT_ICFG_PLB 7

// Operating modes
`define DCT_MODE_13 2'h0
`define DCT_MODE_16 2'h1
`define DCT_MODE_RLD 2'h2
`define DCT_MODE_SPLIT 2'h3

// Prescale codes and divide ratios
`define DCT_PS_A 2'h0
`define DCT_PS_B 2'h1
`define DCT_PS_C 2'h2
`define DCT_PS_EXT 2'h3
`define DCT_DIV_A 6'h0c
`define DCT_DIV_B 6'h04
`define DCT_DIV_C 6'h30
`define DCT_DIV_EXT 6'h08

`endif

// File: core/dct_sync.v
`timescale 1ns/1ps
`default_nettype none
module dct_sync #(
   parameter W = 5
) (
   input wire ref_clk, // System clock
   input wire rst_b, // Async reset, active low
   input wire [W-1:0] din, // Raw pin levels
   output wire [W-1:0] dout, // Synchronised levels
   output wire [W-1:0] fall // One-cycle falling-edge pulses
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   reg [W-1:0] prev_ff;

   // Two stages, then edge detect on the clean sample
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
         prev_ff <= {W{1'b0}};
      end
      else
      begin
         meta_ff <= din;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign dout = sync_ff;
   assign fall = prev_ff & ~sync_ff;
endmodule
`default_nettype wire

// File: core/dct_prescale.v
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.vh"
module dct_prescale #(
   parameter [5:0] DIV_A = `DCT_DIV_A,
   parameter [5:0] DIV_B = `DCT_DIV_B,
   parameter [5:0] DIV_C = `DCT_DIV_C,
   parameter [5:0] DIV_EXT = `DCT_DIV_EXT
) (
   input wire ref_clk, // System clock
   input wire rst_b, // Async reset, active low
   input wire [1:0] prescale_select, // Divide choice
   input wire ext_fall, // One pulse per external clock period
   output reg tick_ff // One-cycle prescaled enable
);
   reg [5:0] cnt_a_ff;
   reg [5:0] cnt_b_ff;
   reg [5:0] cnt_c_ff;
   reg [5:0] cnt_e_ff;
   reg nxt_tick;
   wire end_a = (cnt_a_ff == DIV_A - 6'h01);
   wire end_b = (cnt_b_ff == DIV_B - 6'h01);
   wire end_c = (cnt_c_ff == DIV_C - 6'h01);
   wire end_e = ext_fall && (cnt_e_ff == DIV_EXT - 6'h01);

   always @*
   begin
      case (prescale_select)
         `DCT_PS_A: nxt_tick = end_a;
         `DCT_PS_B: nxt_tick = end_b;
         `DCT_PS_C: nxt_tick = end_c;
         default: nxt_tick = end_e;
      endcase
   end

   // Free-running dividers giving enable pulses, not clocks
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_a_ff <= 6'h00;
         cnt_b_ff <= 6'h00;
         cnt_c_ff <= 6'h00;
         cnt_e_ff <= 6'h00;
         tick_ff <= 1'b0;
      end
      else
      begin
         cnt_a_ff <= end_a ? 6'h00 : cnt_a_ff + 6'h01;
         cnt_b_ff <= end_b ? 6'h00 : cnt_b_ff + 6'h01;
         cnt_c_ff <= end_c ? 6'h00 : cnt_c_ff + 6'h01;
         if (ext_fall)
         begin
            cnt_e_ff <= end_e ? 6'h00 : cnt_e_ff + 6'h01;
         end
         tick_ff <= nxt_tick;
      end
   end
endmodule
`default_nettype wire

// File: core/dct_timer.v
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.vh"
module dct_timer (
   input wire ref_clk, // System clock, 125 MHz
   input wire rst_b, // Async reset, active low
   input wire wb_cyc_i, // Wishbone cycle
   input wire wb_stb_i, // Wishbone strobe
   input wire wb_we_i, // Wishbone write
   input wire [9:0] wb_adr_i, // Byte address
   input wire [3:0] wb_sel_i, // Byte lanes
   input wire [31:0] wb_dat_i, // Write data
   output reg [31:0] wb_dat_o, // Read data
   output reg wb_ack_o, // Cycle acknowledge
   input wire timer_a_event_pin, // Timer A event input
   input wire timer_b_event_pin, // Timer B event input
   input wire ext_irq_a_input, // External input A
   input wire ext_irq_b_input, // External input B
   input wire ext_osc_clk, // External oscillator level
   input wire timer_a_irq_ack, // Vector taken for timer A
   input wire timer_b_irq_ack, // Vector taken for timer B
   input wire tmr_two_alt_tick, // Timer two alternate clock enable
   input wire tmr_three_alt_tick, // Timer three alternate clock enable
   output reg timer_a_irq, // Timer A request
   output reg timer_b_irq, // Timer B request
   output reg timer_a_ovf_pulse, // Timer A overflow event
   output reg timer_b_ovf_pulse, // Timer B overflow event
   output reg tmr_two_low_tick, // Timer two low byte clock enable
   output reg tmr_two_high_tick, // Timer two high byte clock enable
   output reg tmr_three_low_tick, // Timer three low byte clock enable
   output reg tmr_three_high_tick // Timer three high byte clock enable
);
   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Returns {overflow, high, low} after one increment
   function [16:0] dct_step;
      input [1:0] md;
      input [7:0] lo;
      input [7:0] hi;
      reg [13:0] s13;
      reg [16:0] s16;
      reg [8:0] s8;
      begin
         s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
         s16 = {1'b0, hi, lo} + 17'h00001;
         s8 = {1'b0, lo} + 9'h001;
         case (md)
            `DCT_MODE_13: dct_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
            `DCT_MODE_16: dct_step = s16;
            `DCT_MODE_RLD: dct_step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
            default: dct_step = {s8[8], hi, s8[7:0]};
         endcase
      end
   endfunction

   function dct_hit;
      input [7:0] idx;
      input [7:0] code;
      begin
         dct_hit = (idx == code);
      end
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [7:0] timer_clock_select_ff;
   reg [7:0] timer_control_reg_ff;
   reg [7:0] timer_mode_reg_ff;
   reg [7:0] timer_a_low_byte_ff;
   reg [7:0] timer_a_high_byte_ff;
   reg [7:0] timer_b_low_byte_ff;
   reg [7:0] timer_b_high_byte_ff;
   reg [7:0] irq_enable_reg_ff;
   reg [7:0] ext_irq_config_reg_ff;
   reg act_a_prev_ff;
   reg act_b_prev_ff;
   reg [7:0] nxt_ctl;
   reg [7:0] nxt_rd;

   wire [4:0] sync_lvl;
   wire [4:0] sync_fall;
   wire pre_tick;

   // ------------------------------------------------------------
   // Synchronisers and prescaler
   // ------------------------------------------------------------
   dct_sync #(
      .W(5)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .din({ext_osc_clk, ext_irq_b_input, ext_irq_a_input,
            timer_b_event_pin, timer_a_event_pin}),
      .dout(sync_lvl),
      .fall(sync_fall)
   );

   dct_prescale u_pre (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .prescale_select(timer_clock_select_ff[`DCT_CKS_PS+1:`DCT_CKS_PS]),
      .ext_fall(sync_fall[4]),
      .tick_ff(pre_tick)
   );

   // ------------------------------------------------------------
   // Control decode
   // ------------------------------------------------------------
   wire [1:0] md_a = timer_mode_reg_ff[`DCT_MOD_MDA+1:`DCT_MOD_MDA];
   wire [1:0] md_b = timer_mode_reg_ff[`DCT_MOD_MDB+1:`DCT_MOD_MDB];
   wire gate_a = timer_mode_reg_ff[`DCT_MOD_GATEA];
   wire gate_b = timer_mode_reg_ff[`DCT_MOD_GATEB];
   wire cnt_sel_a = timer_mode_reg_ff[`DCT_MOD_CTA];
   wire cnt_sel_b = timer_mode_reg_ff[`DCT_MOD_CTB];
   wire run_a = timer_control_reg_ff[`DCT_CTL_TRA];
   wire run_b = timer_control_reg_ff[`DCT_CTL_TRB];
   wire split_a = (md_a == `DCT_MODE_SPLIT);

   // Active level of the external inputs follows the polarity bits
   wire act_a = ext_irq_config_reg_ff[`DCT_ICFG_PLA] ? sync_lvl[2] : ~sync_lvl[2];
   wire act_b = ext_irq_config_reg_ff[`DCT_ICFG_PLB] ? sync_lvl[3] : ~sync_lvl[3];

   // Clock enables: system clock is every cycle
   wire tick_a = timer_clock_select_ff[`DCT_CKS_TA] | pre_tick;
   wire tick_b = timer_clock_select_ff[`DCT_CKS_TB] | pre_tick;
   wire ev_a = cnt_sel_a ? sync_fall[0] : tick_a;
   wire ev_b = (cnt_sel_b & ~split_a) ? sync_fall[1] : tick_b;

   // Gating
   wire en_a = run_a & (~gate_a | act_a);
   wire en_b_norm = run_b & (~gate_b | act_b);
   wire en_b = (split_a ? 1'b1 : en_b_norm) & (md_b != `DCT_MODE_SPLIT);

   wire inc_a = en_a & ev_a;
   wire inc_b = en_b & ev_b;
   wire inc_ah = split_a & run_b & tick_a;

   wire [16:0] step_a = dct_step(md_a, timer_a_low_byte_ff, timer_a_high_byte_ff);
   wire [16:0] step_b = dct_step(md_b, timer_b_low_byte_ff, timer_b_high_byte_ff);
   wire [8:0] step_ah = {1'b0, timer_a_high_byte_ff} + 9'h001;

   wire ovf_a = inc_a & step_a[16];
   wire ovf_b = inc_b & step_b[16];
   wire ovf_ah = inc_ah & step_ah[8];
   wire set_tf_a = ovf_a;
   wire set_tf_b = split_a ? ovf_ah : ovf_b;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire [7:0] idx = wb_adr_i[9:2];
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = req & wb_we_i & wb_sel_i[0];
   wire [7:0] wd = wb_dat_i[7:0];
   wire wr_ctl = wr & dct_hit(idx, `DCT_IDX_CTL);
   wire wr_tla = wr & dct_hit(idx, `DCT_IDX_TLA);
   wire wr_tha = wr & dct_hit(idx, `DCT_IDX_THA);
   wire wr_tlb = wr & dct_hit(idx, `DCT_IDX_TLB);
   wire wr_thb = wr & dct_hit(idx, `DCT_IDX_THB);

   // External input flags: edge mode catches the active edge, level mode tracks
   wire ie_a_set = timer_control_reg_ff[`DCT_CTL_ITA] ? (act_a & ~act_a_prev_ff) : act_a;
   wire ie_b_set = timer_control_reg_ff[`DCT_CTL_ITB] ? (act_b & ~act_b_prev_ff) : act_b;

   // ------------------------------------------------------------
   // Control register next value
   // ------------------------------------------------------------
   always @*
   begin
      nxt_ctl = wr_ctl ? wd : timer_control_reg_ff;
      if (timer_a_irq_ack)
      begin
         nxt_ctl[`DCT_CTL_TFA] = 1'b0;
      end
      if (timer_b_irq_ack)
      begin
         nxt_ctl[`DCT_CTL_TFB] = 1'b0;
      end
      if (~timer_control_reg_ff[`DCT_CTL_ITA])
      begin
         nxt_ctl[`DCT_CTL_IEA] = act_a;
      end
      else if (ie_a_set)
      begin
         nxt_ctl[`DCT_CTL_IEA] = 1'b1;
      end
      if (~timer_control_reg_ff[`DCT_CTL_ITB])
      begin
         nxt_ctl[`DCT_CTL_IEB] = act_b;
      end
      else if (ie_b_set)
      begin
         nxt_ctl[`DCT_CTL_IEB] = 1'b1;
      end
      // Hardware set wins over any clear in the same cycle
      if (set_tf_a)
      begin
         nxt_ctl[`DCT_CTL_TFA] = 1'b1;
      end
      if (set_tf_b)
      begin
         nxt_ctl[`DCT_CTL_TFB] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always @*
   begin
      case (idx)
         `DCT_IDX_CTL: nxt_rd = timer_control_reg_ff;
         `DCT_IDX_MODE: nxt_rd = timer_mode_reg_ff;
         `DCT_IDX_TLA: nxt_rd = timer_a_low_byte_ff;
         `DCT_IDX_THA: nxt_rd = timer_a_high_byte_ff;
         `DCT_IDX_TLB: nxt_rd = timer_b_low_byte_ff;
         `DCT_IDX_THB: nxt_rd = timer_b_high_byte_ff;
         `DCT_IDX_CLKSEL: nxt_rd = timer_clock_select_ff;
         `DCT_IDX_IEN: nxt_rd = irq_enable_reg_ff;
         `DCT_IDX_ICFG: nxt_rd = ext_irq_config_reg_ff;
         default: nxt_rd = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // Wishbone slave and configuration registers
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         timer_mode_reg_ff <= `DCT_RST_MODE;
         timer_clock_select_ff <= `DCT_RST_CLKSEL;
         irq_enable_reg_ff <= `DCT_RST_IEN;
         ext_irq_config_reg_ff <= `DCT_RST_ICFG;
      end
      else
      begin
         wb_ack_o <= req;
         if (req & ~wb_we_i)
         begin
            wb_dat_o <= {24'h000000, nxt_rd};
         end
         if (wr & dct_hit(idx, `DCT_IDX_MODE))
         begin
            timer_mode_reg_ff <= wd;
         end
         if (wr & dct_hit(idx, `DCT_IDX_CLKSEL))
         begin
            timer_clock_select_ff <= wd;
         end
         if (wr & dct_hit(idx, `DCT_IDX_IEN))
         begin
            irq_enable_reg_ff <= wd;
         end
         if (wr & dct_hit(idx, `DCT_IDX_ICFG))
         begin
            ext_irq_config_reg_ff <= wd;
         end
      end
   end

   // ------------------------------------------------------------
   // Counters and flags
   // ------------------------------------------------------------
   // A software write to a count byte takes precedence over counting
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         timer_control_reg_ff <= `DCT_RST_CTL;
         timer_a_low_byte_ff <= `DCT_RST_CNT;
         timer_a_high_byte_ff <= `DCT_RST_CNT;
         timer_b_low_byte_ff <= `DCT_RST_CNT;
         timer_b_high_byte_ff <= `DCT_RST_CNT;
         act_a_prev_ff <= 1'b0;
         act_b_prev_ff <= 1'b0;
      end
      else
      begin
         timer_control_reg_ff <= nxt_ctl;
         act_a_prev_ff <= act_a;
         act_b_prev_ff <= act_b;
         if (wr_tla)
         begin
            timer_a_low_byte_ff <= wd;
         end
         else if (inc_a)
         begin
            timer_a_low_byte_ff <= step_a[7:0];
         end
         if (wr_tha)
         begin
            timer_a_high_byte_ff <= wd;
         end
         else if (inc_ah)
         begin
            timer_a_high_byte_ff <= step_ah[7:0];
         end
         else if (inc_a & ~split_a)
         begin
            timer_a_high_byte_ff <= step_a[15:8];
         end
         if (wr_tlb)
         begin
            timer_b_low_byte_ff <= wd;
         end
         else if (inc_b)
         begin
            timer_b_low_byte_ff <= step_b[7:0];
         end
         if (wr_thb)
         begin
            timer_b_high_byte_ff <= wd;
         end
         else if (inc_b)
         begin
            timer_b_high_byte_ff <= step_b[15:8];
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         timer_a_irq <= 1'b0;
         timer_b_irq <= 1'b0;
         timer_a_ovf_pulse <= 1'b0;
         timer_b_ovf_pulse <= 1'b0;
         tmr_two_low_tick <= 1'b0;
         tmr_two_high_tick <= 1'b0;
         tmr_three_low_tick <= 1'b0;
         tmr_three_high_tick <= 1'b0;
      end
      else
      begin
         timer_a_irq <= nxt_ctl[`DCT_CTL_TFA] & irq_enable_reg_ff[`DCT_IEN_TA];
         timer_b_irq <= nxt_ctl[`DCT_CTL_TFB] & irq_enable_reg_ff[`DCT_IEN_TB];
         timer_a_ovf_pulse <= ovf_a;
         // Timer B overflow stays visible to other users in split mode
         timer_b_ovf_pulse <= ovf_b;
         tmr_two_low_tick <= timer_clock_select_ff[`DCT_CKS_T2L] | tmr_two_alt_tick;
         tmr_two_high_tick <= timer_clock_select_ff[`DCT_CKS_T2H] | tmr_two_alt_tick;
         tmr_three_low_tick <= timer_clock_select_ff[`DCT_CKS_T3L] | tmr_three_alt_tick;
         tmr_three_high_tick <= timer_clock_select_ff[`DCT_CKS_T3H] | tmr_three_alt_tick;
      end
   end
endmodule
`default_nettype wire

// File: bench/dct_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
module dct_timer_props (
   input wire ref_clk, // Clock
   input wire rst_b, // Reset
   input wire wb_cyc_i, // Cycle
   input wire wb_stb_i, // Strobe
   input wire wb_we_i, // Write
   input wire [31:0] wb_dat_o, // Read data
   input wire wb_ack_o, // Ack
   input wire timer_a_irq_ack, // Vector A
   input wire timer_b_irq_ack, // Vector B
   input wire timer_a_irq, // Request A
   input wire timer_b_irq, // Request B
   input wire timer_a_ovf_pulse, // Overflow A
   input wire timer_b_ovf_pulse, // Overflow B
   input wire tmr_two_alt_tick, // Alt tick 2
   input wire tmr_three_alt_tick, // Alt tick 3
   input wire tmr_two_low_tick, // Tick 2 low
   input wire tmr_two_high_tick, // Tick 2 high
   input wire tmr_three_low_tick, // Tick 3 low
   input wire tmr_three_high_tick // Tick 3 high
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
      else $error("read data changed outside a read");
   t2_tick_a: assert property (tmr_two_alt_tick |=> tmr_two_low_tick && tmr_two_high_tick)
      else $error("timer two tick lost");
   t3_tick_a: assert property (tmr_three_alt_tick |=> tmr_three_low_tick && tmr_three_high_tick)
      else $error("timer three tick lost");
   t2_hold_a: assert property (
      tmr_two_low_tick && !$past(tmr_two_alt_tick) && !wb_ack_o |=> tmr_two_low_tick)
      else $error("system clock tick dropped");
   // Vector clear shows one edge later unless an overflow lands in the same cycle
   irq_clr_a: assert property (
      timer_a_irq_ack && !wb_cyc_i ##1 !timer_a_ovf_pulse |-> !timer_a_irq)
      else $error("timer A request not cleared");
   irq_clr_b_a: assert property (
      timer_b_irq_ack && !wb_cyc_i ##1 !timer_b_ovf_pulse |-> !timer_b_irq)
      else $error("timer B request not cleared");

   cover property (wb_ack_o && !wb_we_i);
   cover property (timer_a_irq_ack && timer_a_irq);
   cover property (timer_b_ovf_pulse);
endmodule

bind dct_timer dct_timer_props chk_u (
   .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .timer_a_irq_ack(timer_a_irq_ack), .timer_b_irq_ack(timer_b_irq_ack),
   .timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq),
   .timer_a_ovf_pulse(timer_a_ovf_pulse), .timer_b_ovf_pulse(timer_b_ovf_pulse),
   .tmr_two_alt_tick(tmr_two_alt_tick), .tmr_three_alt_tick(tmr_three_alt_tick),
   .tmr_two_low_tick(tmr_two_low_tick), .tmr_two_high_tick(tmr_two_high_tick),
   .tmr_three_low_tick(tmr_three_low_tick), .tmr_three_high_tick(tmr_three_high_tick)
);
`default_nettype wire

// File: bench/dct_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.vh"
module dct_timer_bench;
   logic ref_clk, rst_b, cyc, stb, we, ev_a, ev_b, gi_a, gi_b, osc, ak_a, ak_b, alt2, alt3;
   logic [9:0] adr;
   logic [31:0] wdat;
   logic [7:0] q;
   logic [2:0] oc;
   wire [31:0] rdat;
   wire ack, irq_a, irq_b, ovf_a, ovf_b;
   int fails, n_compared, ncyc, na, nb, c0, c1;
   logic [7:0] ix [10] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'ha8, 8'he4, 8'h00};
   logic [7:0] cs [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08};
   int da [6] = '{12, 4, 48, 80, 1, 12};
   int db [6] = '{12, 4, 48, 80, 12, 1};

   dct_timer dut_u (
      .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .timer_a_event_pin(ev_a), .timer_b_event_pin(ev_b), .ext_irq_a_input(gi_a),
      .ext_irq_b_input(gi_b), .ext_osc_clk(osc), .timer_a_irq_ack(ak_a),
      .timer_b_irq_ack(ak_b), .tmr_two_alt_tick(alt2), .tmr_three_alt_tick(alt3),
      .timer_a_irq(irq_a), .timer_b_irq(irq_b), .timer_a_ovf_pulse(ovf_a),
      .timer_b_ovf_pulse(ovf_b), .tmr_two_low_tick(), .tmr_two_high_tick(),
      .tmr_three_low_tick(), .tmr_three_high_tick()
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Free sources, overflow counters, timeout
   // ----------------------------------------
   always @(posedge ref_clk)
   begin
      ncyc <= ncyc + 1;
      oc <= (oc == 3'h4) ? 3'h0 : oc + 3'h1;
      if (oc == 3'h4)
         osc <= ~osc;
      alt2 <= (ncyc % 8 == 0);
      alt3 <= (ncyc % 5 == 0);
      if (ovf_a === 1'b1)
         na <= na + 1;
      if (ovf_b === 1'b1)
         nb <= nb + 1;
      if (ncyc == 30000)
      begin
         fails++;
         end_sim;
      end
   end

   task wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
      begin
         @(posedge ref_clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= {i, 2'b00};
         wdat <= {24'h0, d};
         do @(posedge ref_clk); while (ack !== 1'b1);
         q = rdat[7:0];
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask

   task wr(input logic [7:0] i, input logic [7:0] d);
      bus(1'b1, i, d);
   endtask

   task ck(input logic ok, input string m);
      begin
         n_compared++;
         if (ok !== 1'b1)
         begin
            fails++;
            $display("unexpected at %0t: %s", $time, m);
         end
      end
   endtask

   task rc(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
      begin
         bus(1'b0, i, 8'h00);
         ck((q & m) === e, "register value");
      end
   endtask

   task t_reset;
      begin
         wr(8'h00, 8'hff);
         foreach (ix[k])
            rc(ix[k], 8'hff, 8'h00);
         wr(`DCT_IDX_CLKSEL, 8'h50);
         rc(`DCT_IDX_CLKSEL, 8'hff, 8'h50);
      end
   endtask

   task t_rate;
      begin
         wr(`DCT_IDX_MODE, 8'h22);
         wr(`DCT_IDX_THA, 8'hff);
         wr(`DCT_IDX_TLA, 8'hff);
         wr(`DCT_IDX_THB, 8'hff);
         wr(`DCT_IDX_TLB, 8'hff);
         wr(`DCT_IDX_CTL, 8'h50);
         for (int k = 0; k < 6; k++)
         begin
            wr(`DCT_IDX_CLKSEL, cs[k]);
            wt(4);
            c0 = na;
            c1 = nb;
            wt(960);
            ck((na - c0 - 960 / da[k]) ** 2 <= 1, "rate A");
            ck((nb - c1 - 960 / db[k]) ** 2 <= 1, "rate B");
         end
      end
   endtask

   task t_irq;
      begin
         wr(`DCT_IDX_CTL, 8'h00);
         wr(`DCT_IDX_MODE, 8'h00);
         wr(`DCT_IDX_CLKSEL, 8'h02);
         wr(`DCT_IDX_THA, 8'hff);
         wr(`DCT_IDX_TLA, 8'h1e);
         wr(`DCT_IDX_CTL, 8'h10);
         wt(200);
         rc(`DCT_IDX_CTL, 8'h20, 8'h20);
         ck(irq_a === 1'b0, "request while disabled");
         wr(`DCT_IDX_IEN, 8'h02);
         wt(2);
         ck(irq_a === 1'b1, "request missing");
         ak_a <= 1'b1;
         wt(1);
         ak_a <= 1'b0;
         wt(3);
         ck(irq_a === 1'b0, "request kept");
         wr(`DCT_IDX_CTL, 8'h00);
         rc(`DCT_IDX_THA, 8'hff, 8'h00);
      end
   endtask

   task pulses(input int n);
      begin
         c0 = na;
         c1 = nb;
         repeat (n)
         begin
            ev_a <= 1'b0;
            ev_b <= 1'b0;
            wt(4);
            ev_a <= 1'b1;
            ev_b <= 1'b1;
            wt(4);
         end
         wt(6);
      end
   endtask

   task t_event;
      begin
         // Gate inputs active low until polarity is flipped
         gi_a <= 1'b0;
         gi_b <= 1'b0;
         wr(`DCT_IDX_MODE, 8'hee);
         wr(`DCT_IDX_THA, 8'hff);
         wr(`DCT_IDX_TLA, 8'hff);
         wr(`DCT_IDX_THB, 8'hff);
         wr(`DCT_IDX_TLB, 8'hff);
         wr(`DCT_IDX_CTL, 8'h50);
         pulses(3);
         ck(na - c0 == 3 && nb - c1 == 3, "event count");
         gi_a <= 1'b1;
         gi_b <= 1'b1;
         wt(4);
         pulses(3);
         ck(na - c0 == 0 && nb - c1 == 0, "gated count");
         wr(`DCT_IDX_ICFG, 8'h88);
         pulses(3);
         ck(na - c0 == 3 && nb - c1 == 3, "polarity count");
      end
   endtask

   task t_split;
      begin
         wr(`DCT_IDX_CTL, 8'h00);
         wr(`DCT_IDX_CLKSEL, 8'h04);
         wr(`DCT_IDX_MODE, 8'h03);
         wr(`DCT_IDX_CTL, 8'h40);
         wt(300);
         rc(`DCT_IDX_CTL, 8'ha0, 8'h80);
         wr(`DCT_IDX_CTL, 8'h80);
         wr(`DCT_IDX_IEN, 8'h08);
         wt(2);
         ck(irq_b === 1'b1, "request B missing");
         ak_b <= 1'b1;
         wt(1);
         ak_b <= 1'b0;
         wt(3);
         ck(irq_b === 1'b0, "request B kept");
         wr(`DCT_IDX_CLKSEL, 8'h0c);
         wr(`DCT_IDX_MODE, 8'h33);
         wt(2);
         c1 = nb;
         wr(`DCT_IDX_THB, 8'hff);
         wr(`DCT_IDX_TLB, 8'hff);
         wt(50);
         ck(nb == c1, "inactive timer B");
         wr(`DCT_IDX_MODE, 8'h13);
         wt(300);
         rc(`DCT_IDX_CTL, 8'h80, 8'h00);
         ck(nb - c1 == 1, "split overflow");
      end
   endtask

   task end_sim;
      begin
         $display("compared %0d, failed %0d", n_compared, fails);
         if (fails == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   initial
   begin
      {cyc, stb, we, osc, ak_a, ak_b, alt2, alt3} = 8'h00;
      // Pins idle high, so no gate input is active at reset
      {ev_a, ev_b, gi_a, gi_b} = 4'hf;
      adr = 10'h000;
      wdat = 32'h0;
      oc = 3'h0;
      {ncyc, na, nb, fails, n_compared} = '0;
      rst_b = 1'b0;
      wt(10);
      rst_b <= 1'b1;
      t_reset;
      t_rate;
      t_irq;
      t_event;
      t_split;
      end_sim;
   end
endmodule
`default_nettype wire
